// file: rtl/converter_irq_status_mask.sv
// Status, latched flags and interrupt masks of the four-phase converter
//
// Summary of operation
// RL1 - Bit 4 of the phase 2/3 status register shows phase 3 live current limit.
// RL2 - Bit 0 of the phase 2/3 status register shows phase 2 live current limit.
// RL3 - The phase 2/3 status register is read-only and its reserved bits read zero.
// RL4 - Global mask bit 2, reset 0, gates the thermal-warning interrupt when set.
// RL5 - Masks gate only the interrupt and never change a live status reading.
// RL6 - Global mask bit 1, reset 1, gates the register-reset interrupt when set.
// RL7 - Global mask bit 0, reset 0, gates the load-ready interrupt; bits 7:3 read zero.
// RL8 - Phase 0/1 mask bit 4, reset 1, gates the phase 1 current-limit interrupt.
// RL9 - Phase 0/1 mask bit 2, reset 0, gates the phase 0 power-good interrupt.
// RL10 - Phase 0/1 mask bit 0, reset 0, gates the phase 0 current-limit interrupt.
// RL11 - Each event flag stays set until the host writes one to its bit.
// RL12 - A read-only bit shows live thermal-warning state.
// RL13 - The interrupt output is high while any unmasked flag is set.
// RL14 - Writes to reserved bits are ignored and they read their reset value.
`timescale 1ns/1ps
`default_nettype none
`include "irq_status_mask_defines.svh"
module converter_irq_status_mask
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic phase3_limit_live,
  input wire logic phase2_limit_live,
  input wire logic thermal_warning_live,
  input wire logic thermal_warning_event,
  input wire logic reset_reg_event,
  input wire logic load_ready_event,
  input wire logic phase1_limit_event,
  input wire logic phase0_power_good_event,
  input wire logic phase0_limit_event,
  input wire logic phase3_limit_event,
  input wire logic phase2_limit_event,
  output logic irq_req
);
  irq_status_mask_pkg::reg_byte_t global_irq_mask;
  irq_status_mask_pkg::reg_byte_t phase01_irq_mask;
  irq_status_mask_pkg::reg_byte_t read_mux;
  logic [7:0] flag;

  wire sel_global = reg_addr == `GLOBAL_IRQ_MASK_ADDR;
  wire sel_phase01 = reg_addr == `PHASE01_IRQ_MASK_ADDR;
  wire sel_tflag = reg_addr == `THERMAL_FLAG_ADDR;
  wire sel_p01flag = reg_addr == `PHASE01_FLAG_ADDR;
  wire sel_p23flag = reg_addr == `PHASE23_FLAG_ADDR;
  wire wr_global = reg_write & sel_global;
  wire wr_phase01 = reg_write & sel_phase01;

  // Status bits come straight from the pins, so a mask can never alter them
  wire [7:0] phase23_status = {3'h0, phase3_limit_live, 3'h0, phase2_limit_live}; // see RL1
  wire [7:0] phase23_status_ro = phase23_status & `PHASE23_STATUS_VALID; // see RL2 see RL3 see RL5
  wire [7:0] thermal_status = {5'h00, thermal_warning_live, 2'h0}; // see RL12

  // Clears decode per flag register; writing zero leaves a flag alone
  wire wr_tflag = reg_write & sel_tflag;
  wire wr_p01flag = reg_write & sel_p01flag;
  wire wr_p23flag = reg_write & sel_p23flag;
  wire clear_thermal_warning = wr_tflag & reg_wdata[`THERMAL_WARNING_BIT]; // see RL11
  wire clear_reset_reg = wr_tflag & reg_wdata[`RESET_REG_BIT];
  wire clear_load_ready = wr_tflag & reg_wdata[`LOAD_READY_BIT];
  wire clear_phase1_limit = wr_p01flag & reg_wdata[`PHASE1_LIMIT_BIT];
  wire clear_phase0_power_good = wr_p01flag & reg_wdata[`PHASE0_POWER_GOOD_BIT];
  wire clear_phase0_limit = wr_p01flag & reg_wdata[`PHASE0_LIMIT_BIT];
  wire clear_phase3_limit = wr_p23flag & reg_wdata[`PHASE3_LIMIT_BIT];
  wire clear_phase2_limit = wr_p23flag & reg_wdata[`PHASE2_LIMIT_BIT];

  // Flag order: thermal, reset, load, ph1, ph0 pg, ph0 lim, ph3, ph2
  wire [7:0] flag_event =
  {
    thermal_warning_event,
    reset_reg_event,
    load_ready_event,
    phase1_limit_event,
    phase0_power_good_event,
    phase0_limit_event,
    phase3_limit_event,
    phase2_limit_event
  };
  wire [7:0] flag_clear = // see RL11
  {
    clear_thermal_warning,
    clear_reset_reg,
    clear_load_ready,
    clear_phase1_limit,
    clear_phase0_power_good,
    clear_phase0_limit,
    clear_phase3_limit,
    clear_phase2_limit
  };

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_flag
      sticky_flag u_flag
      (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .event_in(flag_event[i]),
        .clear_in(flag_clear[i]),
        .flag(flag[i])
      );
    end
  endgenerate

  // Named views of the latched flags
  wire thermal_warning_flag = flag[7];
  wire reset_reg_flag = flag[6];
  wire load_ready_flag = flag[5];
  wire phase1_limit_flag = flag[4];
  wire phase0_power_good_flag = flag[3];
  wire phase0_limit_flag = flag[2];
  wire phase3_limit_flag = flag[1];
  wire phase2_limit_flag = flag[0];

  wire thermal_warning_irq_gate = global_irq_mask[`THERMAL_WARNING_BIT]; // see RL4
  wire reset_reg_irq_gate = global_irq_mask[`RESET_REG_BIT]; // see RL6
  wire load_ready_irq_gate = global_irq_mask[`LOAD_READY_BIT]; // see RL7
  wire phase1_limit_irq_gate = phase01_irq_mask[`PHASE1_LIMIT_BIT]; // see RL8
  wire phase0_power_good_irq_gate = phase01_irq_mask[`PHASE0_POWER_GOOD_BIT]; // see RL9
  wire phase0_limit_irq_gate = phase01_irq_mask[`PHASE0_LIMIT_BIT]; // see RL10

  // Phase 2/3 masks are not held here, so those flags always request
  wire thermal_warning_pending = thermal_warning_flag & ~thermal_warning_irq_gate;
  wire reset_reg_pending = reset_reg_flag & ~reset_reg_irq_gate;
  wire load_ready_pending = load_ready_flag & ~load_ready_irq_gate;
  wire phase1_limit_pending = phase1_limit_flag & ~phase1_limit_irq_gate;
  wire phase0_power_good_pending = phase0_power_good_flag & ~phase0_power_good_irq_gate;
  wire phase0_limit_pending = phase0_limit_flag & ~phase0_limit_irq_gate;
  wire phase3_limit_pending = phase3_limit_flag;
  wire phase2_limit_pending = phase2_limit_flag;
  wire next_irq_req = thermal_warning_pending // see RL13
    | reset_reg_pending
    | load_ready_pending
    | phase1_limit_pending
    | phase0_power_good_pending
    | phase0_limit_pending
    | phase3_limit_pending
    | phase2_limit_pending;

  wire [7:0] tflag_view =
  {
    5'h00,
    thermal_warning_flag,
    reset_reg_flag,
    load_ready_flag
  };
  wire [7:0] p01flag_view =
  {
    3'h0,
    phase1_limit_flag,
    1'h0,
    phase0_power_good_flag,
    1'h0,
    phase0_limit_flag
  };
  wire [7:0] p23flag_view =
  {
    3'h0,
    phase3_limit_flag,
    3'h0,
    phase2_limit_flag
  };

  always_comb
  begin
    case (reg_addr)
      `PHASE23_LIMIT_STATUS_ADDR: read_mux = phase23_status_ro;
      `GLOBAL_IRQ_MASK_ADDR: read_mux = global_irq_mask;
      `PHASE01_IRQ_MASK_ADDR: read_mux = phase01_irq_mask;
      `THERMAL_STATUS_ADDR: read_mux = thermal_status;
      `THERMAL_FLAG_ADDR: read_mux = tflag_view;
      `PHASE01_FLAG_ADDR: read_mux = p01flag_view;
      `PHASE23_FLAG_ADDR: read_mux = p23flag_view;
      default: read_mux = 8'h00;
    endcase
  end

  // Reserved positions are masked on write, so they keep reading zero
  wire [7:0] next_global_irq_mask = reg_wdata & `GLOBAL_MASK_VALID; // see RL14
  wire [7:0] next_phase01_irq_mask = reg_wdata & `PHASE01_MASK_VALID; // see RL14

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      global_irq_mask <= `GLOBAL_MASK_RESET;
    else if (wr_global)
      global_irq_mask <= next_global_irq_mask;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      phase01_irq_mask <= `PHASE01_MASK_RESET;
    else if (wr_phase01)
      phase01_irq_mask <= next_phase01_irq_mask;
  end

  // Read data is registered; it lags the address by one cycle and holds between reads
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= read_mux;
  end

  // Registering the request keeps the pin free of decode glitches
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_req <= 1'h0;
    else
      irq_req <= next_irq_req;
  end
endmodule // converter_irq_status_mask
`default_nettype wire

// file: rtl/irq_status_mask_defines.svh
// Register offsets, field positions and reset values of the converter status and mask block
`ifndef IRQ_STATUS_MASK_DEFINES_SVH
`define IRQ_STATUS_MASK_DEFINES_SVH
`define PHASE23_LIMIT_STATUS_ADDR 8'h1d
`define GLOBAL_IRQ_MASK_ADDR 8'h1e
`define PHASE01_IRQ_MASK_ADDR 8'h1f
`define THERMAL_FLAG_ADDR 8'h18
`define PHASE01_FLAG_ADDR 8'h19
`define PHASE23_FLAG_ADDR 8'h1a
`define THERMAL_STATUS_ADDR 8'h1b
`define PHASE3_LIMIT_BIT 4
`define PHASE2_LIMIT_BIT 0
`define THERMAL_WARNING_BIT 2
`define RESET_REG_BIT 1
`define LOAD_READY_BIT 0
`define PHASE1_LIMIT_BIT 4
`define PHASE0_POWER_GOOD_BIT 2
`define PHASE0_LIMIT_BIT 0
`define PHASE23_STATUS_VALID 8'h11
`define GLOBAL_MASK_VALID 8'h07
`define PHASE01_MASK_VALID 8'h15
`define THERMAL_STATUS_VALID 8'h04
`define PHASE23_FLAG_VALID 8'h11
`define GLOBAL_MASK_RESET 8'h02
`define PHASE01_MASK_RESET 8'h10
`define FLAG_RESET 8'h00
`endif

// file: rtl/irq_status_mask_pkg.sv
// Types shared by the converter status and mask block
package irq_status_mask_pkg;
  typedef logic [7:0] reg_byte_t;
endpackage

// file: rtl/sticky_flag.sv
// One latched event flag with write-one-to-clear, where a new event beats the clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic event_in,
  input wire logic clear_in,
  output logic flag
);
  wire next_flag = event_in | (flag & ~clear_in); // see RL11
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 1'h0;
    else
      flag <= next_flag;
  end
endmodule // sticky_flag
`default_nettype wire

// file: sim/irq_status_monitor.sv
// Port checker for the converter status and mask block
`timescale 1ns/1ps
`default_nettype none
module irq_status_monitor
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic irq_req,
  input wire logic phase3_limit_live,
  input wire logic phase2_limit_live,
  input wire logic thermal_warning_live,
  input wire logic phase3_limit_event,
  input wire logic phase2_limit_event,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic rd_stat = reg_read && reg_addr == 8'h1d;
  chk_limit_live: assert property (rd_stat |=> reg_rdata[4] == $past(phase3_limit_live)
    && reg_rdata[0] == $past(phase2_limit_live)) else $error("limit status bit wrong");
  chk_stat_rsvd: assert property (rd_stat |=> (reg_rdata & 8'hee) == 8'h00)
    else $error("status reserved bit set");
  chk_therm_live: assert property (reg_read && reg_addr == 8'h1b |=>
    reg_rdata == {5'h00, $past(thermal_warning_live), 2'h0}) else $error("thermal bit wrong");
  chk_gmask_back: assert property (reg_write && reg_addr == 8'h1e ##1 reg_read &&
    reg_addr == 8'h1e |=> reg_rdata == ($past(reg_wdata, 2) & 8'h07)) else $error("global mask");
  chk_pmask_back: assert property (reg_write && reg_addr == 8'h1f ##1 reg_read &&
    reg_addr == 8'h1f |=> reg_rdata == ($past(reg_wdata, 2) & 8'h15)) else $error("phase mask");
  chk_ph2_irq: assert property (phase2_limit_event |-> ##2 irq_req)
    else $error("phase 2 irq missing");
  chk_ph3_irq: assert property (phase3_limit_event |-> ##2 irq_req)
    else $error("phase 3 irq missing");
  chk_unmapped_zero: assert property (reg_read && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // irq_status_monitor
bind converter_irq_status_mask irq_status_monitor irq_status_monitor_inst
(
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .irq_req(irq_req),
  .phase3_limit_live(phase3_limit_live),
  .phase2_limit_live(phase2_limit_live),
  .thermal_warning_live(thermal_warning_live),
  .phase3_limit_event(phase3_limit_event),
  .phase2_limit_event(phase2_limit_event),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata)
);
`default_nettype wire

// file: sim/host_model.sv
// Host model driving the parallel register port
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial {reg_addr, reg_wdata, reg_write, reg_read} = 18'h0;
  // Optional write, then a read of the same place; idle data is inverted, not left stale
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    {reg_addr, reg_wdata, reg_write, reg_read} = {a, d, w, !w};
    if (w) @(negedge ref_clk);
    if (w) {reg_write, reg_read} = 2'h1;
    @(negedge ref_clk);
    {reg_read, reg_wdata} = {1'h0, ~d};
    q = reg_rdata;
    @(negedge ref_clk);
  endtask
endmodule // host_model
`default_nettype wire

// file: sim/converter_irq_status_mask_test.sv
// Self-checking bench of the converter status and mask block
`timescale 1ns/1ps
`default_nettype none
module converter_irq_status_mask_test;
  logic ref_clk = 1'h0, rst_n, reg_write, reg_read, irq_req;
  logic phase3_limit_live = 1'h0, phase2_limit_live = 1'h0, thermal_warning_live = 1'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q, ev = 8'h00;
  int error_cnt = 0, n_checks = 0;
  // Rows: live {ph3, ph2, thermal}, address, write data, expected readback
  logic [26:0] rows [8] = '{27'h01eff07, 27'h01fff15, 27'h61dff11, 27'h41d0010,
    27'h11bff04, 27'h030ff00, 27'h01e0000, 27'h01f0000};
  // Rows: event index, irq expected, flag address, clear data that is also the flag readback
  logic [19:0] evt [8] = '{20'h11804, 20'h21802, 20'h51801, 20'h61910,
    20'h91904, 20'hb1901, 20'hd1a10, 20'hf1a01};
  converter_irq_status_mask converter_irq_status_mask_inst
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .phase3_limit_live(phase3_limit_live),
    .phase2_limit_live(phase2_limit_live),
    .thermal_warning_live(thermal_warning_live),
    .thermal_warning_event(ev[0]),
    .reset_reg_event(ev[1]),
    .load_ready_event(ev[2]),
    .phase1_limit_event(ev[3]),
    .phase0_power_good_event(ev[4]),
    .phase0_limit_event(ev[5]),
    .phase3_limit_event(ev[6]),
    .phase2_limit_event(ev[7]),
    .irq_req(irq_req)
  );
  host_model host_model_inst
  (
    .ref_clk(ref_clk),
    .reg_rdata(reg_rdata),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read)
  );
  always #2 ref_clk = ~ref_clk;
  task automatic check(input logic [7:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wi(input logic [7:0] a, d, r, input logic e);
    host_model_inst.acc(1'h1, a, d, q);
    check(q, r, "readback after write");
    check({7'h0, irq_req}, {7'h0, e}, "irq after write");
  endtask
  task automatic pulse(input int b);
    ev[b] = 1'h1;
    @(negedge ref_clk);
    ev = 8'h00;
    @(negedge ref_clk);
  endtask
  task automatic reset_dut;
    rst_n = 1'h0;
    repeat (4) @(negedge ref_clk);
    check({7'h0, irq_req}, 8'h00, "irq in reset");
    check(reg_rdata, 8'h00, "rdata in reset");
    rst_n = 1'h1;
    @(negedge ref_clk);
    host_model_inst.acc(1'h0, 8'h1e, 8'h00, q);
    check(q, 8'h02, "global mask reset");
    host_model_inst.acc(1'h0, 8'h1f, 8'h00, q);
    check(q, 8'h10, "phase mask reset");
    $display("reset test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    reset_dut;
    foreach (rows[i])
    begin
      {phase3_limit_live, phase2_limit_live, thermal_warning_live} = rows[i][26:24];
      host_model_inst.acc(1'h1, rows[i][23:16], rows[i][15:8], q);
      check(q, rows[i][7:0], "readback");
      $display("register row %0d done", i);
    end
    // Second reset mid-run also proves the masks return to their defaults
    reset_dut;
    foreach (evt[i])
    begin
      pulse(evt[i][19:17]);
      check({7'h0, irq_req}, {7'h0, evt[i][16]}, "irq");
      host_model_inst.acc(1'h0, evt[i][15:8], 8'h00, q);
      check(q, evt[i][7:0], "flag latched");
      wi(evt[i][15:8], evt[i][7:0], 8'h00, 1'h0);
      $display("event row %0d done", i);
    end
    pulse(5);
    wi(8'h19, 8'h00, 8'h01, 1'h1);
    wi(8'h1f, 8'h01, 8'h01, 1'h0);
    wi(8'h1f, 8'h00, 8'h00, 1'h1);
    wi(8'h19, 8'h01, 8'h00, 1'h0);
    $display("mask while pending test done");
    // The event is dropped after the clearing edge, so only a set-wins flag reads back one
    ev[5] = 1'h1;
    fork
      host_model_inst.acc(1'h1, 8'h19, 8'h01, q);
      begin
        @(negedge ref_clk);
        ev = 8'h00;
      end
    join
    check(q, 8'h01, "flag after clear collision");
    check({7'h0, irq_req}, 8'h01, "irq after clear collision");
    wi(8'h19, 8'h01, 8'h00, 1'h0);
    $display("clear collision test done");
    complete_run;
  end
  // Tests need well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    complete_run;
  end
endmodule // converter_irq_status_mask_test
`default_nettype wire
